// ### hdl/vss_decode.sv
`timescale 1ns/1ps
`include "vss_regs.svh"
// Maps code plus modifier to line count, field rate, subcarrier and flags
module vss_decode (
  input wire logic [2:0] code_in,
  input wire logic modifier_in,
  output logic lines625_out,
  output logic field50_out,
  output logic [1:0] carrier_out,
  output logic mono_out,
  output logic simple_pal_out,
  output logic comp_ntsc_out
);
  always_comb begin
    lines625_out = 1'b0;
    field50_out = 1'b0;
    carrier_out = 2'h0;
    mono_out = 1'b0;
    simple_pal_out = 1'b0;
    comp_ntsc_out = 1'b0;
    // Carrier 0: 4.433618, 1: 3.579545, 2: 4.286 FM, 3: PAL M/N carriers
    case (vss_pkg::vss_std_t'(code_in))
      vss_pkg::VSS_PAL: begin
        lines625_out = 1'b1;
        field50_out = 1'b1;
        simple_pal_out = modifier_in;
      end
      vss_pkg::VSS_NTSC: begin
        carrier_out = 2'h1;
        comp_ntsc_out = modifier_in;
      end
      vss_pkg::VSS_SECAM: begin
        lines625_out = 1'b1;
        field50_out = 1'b1;
        carrier_out = 2'h2;
        mono_out = modifier_in;
      end
      vss_pkg::VSS_NTSC443: begin
        comp_ntsc_out = modifier_in;
      end
      vss_pkg::VSS_PAL_M: begin
        carrier_out = 2'h3;
        simple_pal_out = modifier_in;
      end
      vss_pkg::VSS_PAL_N: begin
        lines625_out = 1'b1;
        field50_out = 1'b1;
        carrier_out = 2'h3;
        simple_pal_out = modifier_in;
      end
      vss_pkg::VSS_PAL60: begin
        simple_pal_out = modifier_in;
      end
      vss_pkg::VSS_NTSC_FILT: begin
        carrier_out = 2'h1;
        mono_out = modifier_in;
      end
      default: begin
        lines625_out = 1'b0;
      end
    endcase
  end
endmodule // vss_decode

// ### hdl/vss_pkg.sv
package vss_pkg;
  typedef enum logic [2:0] {
    VSS_PAL = 3'h0,
    VSS_NTSC = 3'h1,
    VSS_SECAM = 3'h2,
    VSS_NTSC443 = 3'h3,
    VSS_PAL_M = 3'h4,
    VSS_PAL_N = 3'h5,
    VSS_PAL60 = 3'h6,
    VSS_NTSC_FILT = 3'h7
  } vss_std_t;
  typedef enum logic [1:0] {
    VSS_IN_COMPOSITE = 2'h0,
    VSS_IN_COMB = 2'h1,
    VSS_IN_SEPARATE = 2'h2,
    VSS_IN_NO_NOTCH = 2'h3
  } vss_input_t;
  typedef enum logic [2:0] {
    VSS_ST_IDLE = 3'b000,
    VSS_ST_LOOP = 3'b001,
    VSS_ST_VERT = 3'b010,
    VSS_ST_CLK = 3'b011,
    VSS_ST_COMB = 3'b100,
    VSS_ST_DONE = 3'b101
  } vss_state_t;
endpackage

// ### hdl/vss_regs.svh
// Summary of operation
// - Reset loads all selection fields to zero
// - Standard change reloads standard-dependent registers
// - Three-bit code picks one of eight standards
// - Modifier bit alters the selected standard
// - Separate-input and comb bits pick input mode
// - Option bits skip individual re-initialisation parts
// - Completion bit set when switch finishes
`ifndef VSS_REGS_SVH
`define VSS_REGS_SVH
`define VSS_ADDR_W 8
`define VSS_STD_SEL_ADDR 8'h20
`define VSS_STD_SEL_RESET 12'h000
`define VSS_CODE_LSB 0
`define VSS_CODE_MSB 2
`define VSS_MOD_BIT 3
`define VSS_HELPER_BIT 4
`define VSS_COMB_BIT 5
`define VSS_SEP_BIT 6
`define VSS_OPT_LSB 7
`define VSS_OPT_MSB 10
`define VSS_DONE_BIT 11
`define VSS_STEP_CYCLES 4'h4
`endif

// ### hdl/vss_std_select.sv
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
`include "vss_regs.svh"
module vss_std_select (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic [7:0] addr_in,
  input wire logic [11:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [11:0] rdata_out,
  output logic [2:0] std_code_out,
  output logic standard_modifier_out,
  output logic wide_screen_helper_mode_out,
  output logic [1:0] input_mode_out,
  output logic [3:0] init_suppress_options_out,
  output logic lines625_out,
  output logic field50_out,
  output logic [1:0] carrier_out,
  output logic mono_out,
  output logic simple_pal_out,
  output logic comp_ntsc_out,
  output logic reload_loop_out,
  output logic reload_vert_out,
  output logic reload_clk_out,
  output logic reload_comb_out,
  output logic busy_out
);
  logic [10:0] ctrl;
  logic done_flag;
  vss_pkg::vss_state_t state;
  vss_pkg::vss_state_t next_state;
  logic step_start;
  logic step_done;
  logic hit_wr;
  logic dec_625, dec_50, dec_mono, dec_spal, dec_cntsc;
  logic [1:0] dec_car;

  assign hit_wr = wr_in && (addr_in == `VSS_STD_SEL_ADDR);

  // Register fields; the status bit is not software-settable
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ctrl <= 11'(`VSS_STD_SEL_RESET);
    end else if (hit_wr) begin
      ctrl <= wdata_in[10:0];
    end
  end

  // Step order through the re-initialisation; skipped parts jump past
  function automatic vss_pkg::vss_state_t step_after(
    input vss_pkg::vss_state_t s, input logic [3:0] skip);
    vss_pkg::vss_state_t r;
    r = vss_pkg::VSS_ST_DONE;
    if (s == vss_pkg::VSS_ST_IDLE && !skip[0]) begin
      r = vss_pkg::VSS_ST_LOOP;
    end else if (s <= vss_pkg::VSS_ST_LOOP && !skip[1]) begin
      r = vss_pkg::VSS_ST_VERT;
    end else if (s <= vss_pkg::VSS_ST_VERT && !skip[2]) begin
      r = vss_pkg::VSS_ST_CLK;
    end else if (s <= vss_pkg::VSS_ST_CLK && !skip[3]) begin
      r = vss_pkg::VSS_ST_COMB;
    end
    return r;
  endfunction

  always_comb begin
    next_state = state;
    step_start = 1'b0;
    case (state)
      vss_pkg::VSS_ST_IDLE: begin
        if (hit_wr) begin
          next_state = step_after(state, wdata_in[10:7]);
          step_start = 1'b1;
        end
      end
      vss_pkg::VSS_ST_LOOP, vss_pkg::VSS_ST_VERT,
      vss_pkg::VSS_ST_CLK, vss_pkg::VSS_ST_COMB: begin
        if (hit_wr) begin
          // A new write restarts the sequence from the top
          next_state = step_after(vss_pkg::VSS_ST_IDLE, wdata_in[10:7]);
          step_start = 1'b1;
        end else if (step_done) begin
          next_state = step_after(state, ctrl[10:7]);
          step_start = 1'b1;
        end
      end
      vss_pkg::VSS_ST_DONE: begin
        // A write on the closing cycle must still start its own switch
        if (hit_wr) begin
          next_state = step_after(vss_pkg::VSS_ST_IDLE, wdata_in[10:7]);
          step_start = 1'b1;
        end else begin
          next_state = vss_pkg::VSS_ST_IDLE;
        end
      end
      default: begin
        next_state = vss_pkg::VSS_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state <= vss_pkg::VSS_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  vss_timer u_timer (
    .clk_sys_in(clk_sys_in),
    .rstn_in(rstn_in),
    .start_in(step_start && next_state != vss_pkg::VSS_ST_DONE),
    .done_out(step_done)
  );

  // Hardware set beats a software clear in the same cycle
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      done_flag <= 1'b0;
    end else if (state == vss_pkg::VSS_ST_DONE) begin
      done_flag <= 1'b1;
    end else if (hit_wr) begin
      done_flag <= wdata_in[`VSS_DONE_BIT] & done_flag;
    end
  end

  vss_decode u_decode (
    .code_in(ctrl[`VSS_CODE_MSB:`VSS_CODE_LSB]),
    .modifier_in(ctrl[`VSS_MOD_BIT]),
    .lines625_out(dec_625),
    .field50_out(dec_50),
    .carrier_out(dec_car),
    .mono_out(dec_mono),
    .simple_pal_out(dec_spal),
    .comp_ntsc_out(dec_cntsc)
  );

  // Standard-dependent settings load in the DONE state, after the last step has finished
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      lines625_out <= 1'b1;
      field50_out <= 1'b1;
      carrier_out <= 2'h0;
      mono_out <= 1'b0;
      simple_pal_out <= 1'b0;
      comp_ntsc_out <= 1'b0;
    end else if (state == vss_pkg::VSS_ST_DONE) begin
      lines625_out <= dec_625;
      field50_out <= dec_50;
      carrier_out <= dec_car;
      mono_out <= dec_mono;
      simple_pal_out <= dec_spal;
      comp_ntsc_out <= dec_cntsc;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      reload_loop_out <= 1'b0;
      reload_vert_out <= 1'b0;
      reload_clk_out <= 1'b0;
      reload_comb_out <= 1'b0;
      busy_out <= 1'b0;
    end else begin
      reload_loop_out <= (next_state == vss_pkg::VSS_ST_LOOP);
      reload_vert_out <= (next_state == vss_pkg::VSS_ST_VERT);
      reload_clk_out <= (next_state == vss_pkg::VSS_ST_CLK);
      reload_comb_out <= (next_state == vss_pkg::VSS_ST_COMB);
      busy_out <= (next_state != vss_pkg::VSS_ST_IDLE);
    end
  end

  // Field outputs follow the register directly
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      std_code_out <= 3'h0;
      standard_modifier_out <= 1'b0;
      wide_screen_helper_mode_out <= 1'b0;
      input_mode_out <= 2'h0;
      init_suppress_options_out <= 4'h0;
    end else if (hit_wr) begin
      std_code_out <= wdata_in[`VSS_CODE_MSB:`VSS_CODE_LSB];
      standard_modifier_out <= wdata_in[`VSS_MOD_BIT];
      wide_screen_helper_mode_out <= wdata_in[`VSS_HELPER_BIT];
      input_mode_out <= {wdata_in[`VSS_SEP_BIT],
                         wdata_in[`VSS_COMB_BIT]};
      init_suppress_options_out <=
        wdata_in[`VSS_OPT_MSB:`VSS_OPT_LSB];
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata_out <= 12'h000;
    end else if (rd_in && addr_in == `VSS_STD_SEL_ADDR) begin
      rdata_out <= {done_flag, ctrl};
    end else begin
      rdata_out <= 12'h000;
    end
  end

  reset_fields_a: assert property (
    @(posedge clk_sys_in) $rose(rstn_in) |-> ctrl == 11'h000 && !done_flag)
    else $error("fields not zero after reset");
  done_after_seq_a: assert property (
    @(posedge clk_sys_in) disable iff (!rstn_in)
    state == vss_pkg::VSS_ST_DONE |=> done_flag)
    else $error("completion bit not set after switch");
  skip_loop_a: assert property (
    @(posedge clk_sys_in) disable iff (!rstn_in)
    hit_wr && wdata_in[7] |=> state != vss_pkg::VSS_ST_LOOP)
    else $error("skipped colour loop step ran");
  write_starts_a: assert property (
    @(posedge clk_sys_in) disable iff (!rstn_in)
    hit_wr |-> ##[1:17] (state == vss_pkg::VSS_ST_DONE || hit_wr))
    else $error("re-initialisation did not finish");
  input_mode_a: assert property (
    @(posedge clk_sys_in) disable iff (!rstn_in)
    hit_wr |=> input_mode_out == {$past(wdata_in[6]), $past(wdata_in[5])})
    else $error("input mode mismatch");
  helper_mode_a: assert property (
    @(posedge clk_sys_in) disable iff (!rstn_in)
    hit_wr |=> wide_screen_helper_mode_out == $past(wdata_in[4]))
    else $error("helper mode mismatch");
  code_out_a: assert property (
    @(posedge clk_sys_in) disable iff (!rstn_in)
    !hit_wr |=> $stable(std_code_out))
    else $error("standard code moved without write");
  modifier_a: assert property (
    @(posedge clk_sys_in) disable iff (!rstn_in)
    state == vss_pkg::VSS_ST_DONE && ctrl[3:0] == 4'h8 |=> simple_pal_out)
    else $error("modifier did not give simple PAL");

  code_write_a: assert property (
    @(posedge clk_sys_in) disable iff (!rstn_in)
    hit_wr |=> std_code_out == $past(wdata_in[`VSS_CODE_MSB:`VSS_CODE_LSB]))
    else $error("standard code not taken from write");
  modifier_write_a: assert property (
    @(posedge clk_sys_in) disable iff (!rstn_in)
    hit_wr |=> standard_modifier_out == $past(wdata_in[`VSS_MOD_BIT]))
    else $error("modifier not taken from write");
  options_write_a: assert property (
    @(posedge clk_sys_in) disable iff (!rstn_in)
    hit_wr |=> init_suppress_options_out ==
      $past(wdata_in[`VSS_OPT_MSB:`VSS_OPT_LSB]))
    else $error("options not taken from write");

  loop_skipped_a: assert property (
    @(posedge clk_sys_in) disable iff (!rstn_in)
    ctrl[`VSS_OPT_LSB] |-> state != vss_pkg::VSS_ST_LOOP)
    else $error("suppressed colour loop step ran");
  vert_skipped_a: assert property (
    @(posedge clk_sys_in) disable iff (!rstn_in)
    ctrl[`VSS_OPT_LSB + 1] |-> state != vss_pkg::VSS_ST_VERT)
    else $error("suppressed vertical step ran");
  clk_skipped_a: assert property (
    @(posedge clk_sys_in) disable iff (!rstn_in)
    ctrl[`VSS_OPT_LSB + 2] |-> state != vss_pkg::VSS_ST_CLK)
    else $error("suppressed clock step ran");
  comb_skipped_a: assert property (
    @(posedge clk_sys_in) disable iff (!rstn_in)
    ctrl[`VSS_OPT_MSB] |-> state != vss_pkg::VSS_ST_COMB)
    else $error("suppressed comb step ran");

  one_step_a: assert property (
    @(posedge clk_sys_in) disable iff (!rstn_in)
    $onehot0({reload_comb_out, reload_clk_out, reload_vert_out,
      reload_loop_out}))
    else $error("two setup steps at once");
  dep_hold_a: assert property (
    @(posedge clk_sys_in) disable iff (!rstn_in)
    state != vss_pkg::VSS_ST_DONE |=> $stable({lines625_out, field50_out,
      carrier_out, mono_out, simple_pal_out, comp_ntsc_out}))
    else $error("dependent setting moved outside a switch");
  step_len_a: assert property (
    @(posedge clk_sys_in) disable iff (!rstn_in)
    state == vss_pkg::VSS_ST_VERT && $past(state) == vss_pkg::VSS_ST_LOOP &&
      !$past(hit_wr) |-> $past(state, 4) == vss_pkg::VSS_ST_LOOP)
    else $error("colour loop step too short");

  secam_load_a: assert property (
    @(posedge clk_sys_in) disable iff (!rstn_in)
    state == vss_pkg::VSS_ST_DONE && ctrl[2:0] == 3'h2 |=>
      carrier_out == 2'h2 && lines625_out && field50_out)
    else $error("wrong settings for third standard");
  ntsc_load_a: assert property (
    @(posedge clk_sys_in) disable iff (!rstn_in)
    state == vss_pkg::VSS_ST_DONE && ctrl[2:0] == 3'h1 |=>
      carrier_out == 2'h1 && !lines625_out && !field50_out)
    else $error("wrong settings for second standard");
  mono_secam_a: assert property (
    @(posedge clk_sys_in) disable iff (!rstn_in)
    state == vss_pkg::VSS_ST_DONE && ctrl[3:0] == 4'hA |=>
      mono_out && lines625_out)
    else $error("modifier did not give 625 line mono");
  mono_filt_a: assert property (
    @(posedge clk_sys_in) disable iff (!rstn_in)
    state == vss_pkg::VSS_ST_DONE && ctrl[3:0] == 4'hF |=>
      mono_out && !lines625_out)
    else $error("modifier did not give 525 line mono");
  comp_ntsc_a: assert property (
    @(posedge clk_sys_in) disable iff (!rstn_in)
    state == vss_pkg::VSS_ST_DONE && ctrl[3:0] == 4'h9 |=> comp_ntsc_out)
    else $error("modifier did not give compensated mode");

  done_clear_a: assert property (
    @(posedge clk_sys_in) disable iff (!rstn_in)
    hit_wr && !wdata_in[`VSS_DONE_BIT] &&
      state != vss_pkg::VSS_ST_DONE |=> !done_flag)
    else $error("status bit not cleared by write");
  done_early_a: assert property (
    @(posedge clk_sys_in) disable iff (!rstn_in)
    !done_flag && state != vss_pkg::VSS_ST_DONE |=> !done_flag)
    else $error("status bit set before switch ended");
  busy_done_a: assert property (
    @(posedge clk_sys_in) disable iff (!rstn_in)
    $fell(busy_out) |-> done_flag)
    else $error("switch ended without status bit");
  read_back_a: assert property (
    @(posedge clk_sys_in) disable iff (!rstn_in)
    rd_in && addr_in == `VSS_STD_SEL_ADDR |=>
      rdata_out == {$past(done_flag), $past(ctrl)})
    else $error("read data does not match register");
endmodule // vss_std_select

// ### hdl/vss_timer.sv
`timescale 1ns/1ps
`include "vss_regs.svh"
// Counts out one setup step; done pulses when the step finishes
module vss_timer (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic start_in,
  output logic done_out
);
  logic [3:0] count;
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      count <= 4'h0;
    end else if (start_in) begin
      count <= `VSS_STEP_CYCLES;
    end else if (count != 4'h0) begin
      count <= count - 4'h1;
    end
  end
  assign done_out = (count == 4'h1);
endmodule // vss_timer

// ### verification/vss_std_select_tb_top.sv
`timescale 1ns/1ps
module vss_std_select_tb_top;
  logic clk_sys_in, rstn_in, wr_in, rd_in, busy_out;
  logic [7:0] addr_in;
  logic [11:0] wdata_in, rdata_out, rd_v, d;
  logic [2:0] std_code_out;
  logic standard_modifier_out, wide_screen_helper_mode_out;
  logic [1:0] input_mode_out, carrier_out;
  logic [3:0] init_suppress_options_out, rl, seen, first, j, ns;
  logic lines625_out, field50_out, mono_out, simple_pal_out, comp_ntsc_out;
  logic reload_loop_out, reload_vert_out, reload_clk_out, reload_comb_out;
  logic [6:0] msk;
  logic [3:0] sk [6] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'hF};
  int n_fail = 0;
  int checks = 0;
  int nb;

  assign rl = {reload_comb_out, reload_clk_out, reload_vert_out,
    reload_loop_out};

  vss_std_select dut (
    .clk_sys_in, .rstn_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
    .std_code_out, .standard_modifier_out, .wide_screen_helper_mode_out,
    .input_mode_out, .init_suppress_options_out, .lines625_out,
    .field50_out, .carrier_out, .mono_out, .simple_pal_out, .comp_ntsc_out,
    .reload_loop_out, .reload_vert_out, .reload_clk_out, .reload_comb_out,
    .busy_out
  );

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [11:0] v);
    @(posedge clk_sys_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= v;
    @(posedge clk_sys_in);
    wr_in <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_sys_in);
    rd_in <= 1'b0;
    #1;
    rd_v = rdata_out;
  endtask

  // Counts busy cycles and collects which setup steps ran
  task automatic wt();
    #1;
    nb = 0;
    seen = 4'h0;
    first = rl;
    while (busy_out === 1'b1 && nb < 40) begin
      seen = seen | rl;
      nb++;
      @(posedge clk_sys_in);
      #1;
    end
  endtask

  // Mono and modifier flags are only pinned down for codes 0, 1, 2 and 7
  function automatic logic [6:0] dep(input logic [2:0] c, input logic m);
    logic f50;
    logic [1:0] cr;
    f50 = (c == 3'h0 || c == 3'h2 || c == 3'h5);
    cr = (c == 3'h2) ? 2'h2 : (c == 3'h4 || c == 3'h5) ? 2'h3 :
      (c == 3'h1 || c == 3'h7) ? 2'h1 : 2'h0;
    dep = {f50, f50, cr, m && (c == 3'h2 || c == 3'h7), m && c == 3'h0,
      m && c == 3'h1};
  endfunction

  task automatic summarize();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end

  // Whole run is well under a thousand cycles
  initial begin
    #50000;
    n_fail++;
    summarize();
  end

  initial begin
    rstn_in = 1'b0;
    wr_in = 1'b0;
    rd_in = 1'b0;
    addr_in = 8'h00;
    wdata_in = 12'h000;
    repeat (10) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    #1;
    chk({std_code_out, standard_modifier_out, wide_screen_helper_mode_out,
      input_mode_out, init_suppress_options_out}, 12'h000);
    chk({lines625_out, field50_out, carrier_out, mono_out, simple_pal_out,
      comp_ntsc_out, busy_out, rl}, 12'hC00);
    rd(8'h20);
    chk(rd_v, 12'h000);
    foreach (sk[k]) begin
      ns = ~sk[k];
      wr(8'h20, {1'b0, sk[k], 7'h01});
      wt();
      chk(nb[11:0], 12'(1 + 4 * $countones(ns)));
      chk({8'h00, seen}, {8'h00, ns});
      chk({8'h00, first}, {8'h00, ns & (~ns + 4'h1)});
      rd(8'h20);
      chk(rd_v, {1'b1, sk[k], 7'h01});
    end
    // Writing one to the status bit must not set it early; clear it first
    wr(8'h20, 12'h000);
    wr(8'h20, 12'h800);
    rd(8'h20);
    chk(rd_v, 12'h000);
    wt();
    rd(8'h20);
    chk(rd_v, 12'h800);
    // A second write in mid-switch starts the sequence again
    wr(8'h20, 12'h000);
    repeat (3) @(posedge clk_sys_in);
    wr(8'h20, 12'h000);
    wt();
    chk(nb[11:0], 12'd17);
    for (int i = 0; i < 16; i++) begin
      j = i[3:0];
      d = {1'b0, 4'hF, j[1], j[0], j[2], j[3], j[2:0]};
      wr(8'h20, d);
      wt();
      chk({1'b0, d[2:0], d[3], d[4], d[6:5], d[10:7]},
        {1'b0, std_code_out, standard_modifier_out,
        wide_screen_helper_mode_out, input_mode_out,
        init_suppress_options_out});
      msk = !j[3] ? 7'h7F : (j[2:0] inside {3'h0, 3'h1, 3'h2, 3'h7}) ?
        7'h67 : 7'h60;
      chk({5'h00, msk & {lines625_out, field50_out, carrier_out, mono_out,
        simple_pal_out, comp_ntsc_out}},
        {5'h00, msk & dep(j[2:0], j[3])});
    end
    // Other addresses are ignored and read as zero
    wr(8'h21, 12'h7F0);
    #1;
    chk({8'h00, busy_out, std_code_out}, 12'h007);
    rd(8'h21);
    chk(rd_v, 12'h000);
    rd(8'h20);
    chk(rd_v, 12'hFFF);
    @(posedge clk_sys_in);
    #1;
    chk(rdata_out, 12'h000);
    summarize();
  end
endmodule // vss_std_select_tb_top
